// [hw/ldc_ctrl.sv]
// Control logic of a two-channel LED driver with an integrated DC-DC converter.
// Pins arrive asynchronously; analog comparators and the converter power stage sit outside.
// Overview of operation
// R01: Lock switching to external 300 kHz..2.2 MHz clock.
// R02: Sync lost: keep switching at resistor frequency.
// R03: Lost with sync low: no spread, immediately.
// R04: Lost with sync high: spread after 256 us.
// R05: Static low/high sets spread; toggling selects sync.
// R06: Spread modulates plus/minus 3% at 1 kHz.
// R07: External sync forces spread spectrum off.
// R08: Host sync is 1.2..1.5 times resistor frequency.
// R09: Frequency picks off time and blanking set.
// R10: Limit 2 A, boosted 2.5 A for 1.5 s.
// R11: Continuous overload alternates limits every 1.5 s.
// R12: Grounded sinks found at start-up, then disabled.
// R13: Sink pattern follows input PWM directly.
// R14: Host PWM lies between 100 Hz and 20 kHz.
// R15: Shortest PWM on/off interval is 0.5 us.
// R16: Start at 88 percent, then adapt output.
// R17: Ramp power FET gate current to 230 uA.
// R18: Shutdown switches the power FET off.
// R19: Recovery state switches the power FET off.
// R20: Enable pin high enables the device.
// R21: Detect faults, signal on open-drain fault output.
// R22: Recovery 100 ms, then active if fault gone.
// R23: Sync qualified after several in-range edge periods.
module ldc_ctrl
  import ldc_pkg::*;
#(
  parameter int SS_DELAY_CYC  = SS_DELAY_US * CLK_MHZ,
  parameter int ILIM_CYC      = ILIM_MS * 1000 * CLK_MHZ,
  parameter int RECOV_CYC     = RECOV_MS * 1000 * CLK_MHZ,
  parameter int GATE_STEP_CYC = 100
) (
  // Clock, reset, clock enable.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Host pins.
  input  wire logic        io_supply_enable_input,
  input  wire logic        pwm_in,
  input  wire logic        sync_in,
  // Analog status inputs.
  input  wire ldc_faults_t fault_in,
  input  wire logic        vin_above_vgs,
  input  wire logic        ilim_reached,
  input  wire logic [1:0]  sink_grounded,
  input  wire logic [1:0]  open_led,
  input  wire logic [1:0]  short_led,
  input  wire logic [11:0] fsw_khz,
  // Converter and sink controls.
  output ldc_dcdc_t        dcdc,
  output logic             led_sink_one,
  output logic             led_sink_two,
  output logic [1:0]       sink_disabled,
  output logic [7:0]       power_fet_gate_control,
  // Open-drain fault pin.
  output logic             fault_pin_out,
  output logic             fault_pin_oe
);
  if (SS_DELAY_CYC < 1 || ILIM_CYC < 1 || RECOV_CYC < 1 || GATE_STEP_CYC < 1) begin : g_chk
    $error("ldc_ctrl: timing parameters must be at least one cycle.");
  end

  logic [6:0] meta_ff;
  logic [6:0] pin_ff;
  logic       sync_prev_ff;
  logic       en_s;
  logic       pwm_s;
  logic       sync_s;
  logic       sync_edge;
  ldc_faults_t flt_s;
  logic       any_flt;

  // Two-flop synchronisers for the enable, PWM, sync and fault pins; the other analog status inputs are used directly.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff      <= 7'h00;
      pin_ff       <= 7'h00;
      sync_prev_ff <= 1'b0;
    end else if (clk_en) begin
      meta_ff      <= {io_supply_enable_input, pwm_in, sync_in, fault_in};
      pin_ff       <= meta_ff;
      sync_prev_ff <= pin_ff[4];
    end
  end
  assign en_s      = pin_ff[6];
  assign pwm_s     = pin_ff[5];
  assign sync_s    = pin_ff[4];
  assign flt_s     = pin_ff[3:0];
  assign any_flt   = |flt_s;
  assign sync_edge = sync_s & ~sync_prev_ff;

  // Device state.
  ldc_state_t state_ff;
  logic [31:0] en_low_cnt_ff;
  logic [31:0] rec_cnt_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff      <= ST_STBY;
      en_low_cnt_ff <= '0;
      rec_cnt_ff    <= '0;
    end else if (clk_en) begin
      en_low_cnt_ff <= en_s ? 32'h0 : en_low_cnt_ff + 32'h1;
      unique case (state_ff)
        ST_STBY: if (en_s) state_ff <= ST_INIT;  // R20
        ST_INIT: state_ff <= any_flt ? ST_REC : ST_ACT;
        ST_ACT: begin
          if (en_low_cnt_ff >= EN_SHORT_CYC) state_ff <= ST_STBY;
          else if (any_flt) state_ff <= ST_REC;  // R21
        end
        ST_REC: begin
          if (en_low_cnt_ff >= EN_SHORT_CYC) state_ff <= ST_STBY;
          else if (rec_cnt_ff >= RECOV_CYC - 1 && !any_flt) state_ff <= ST_ACT;  // R22
        end
      endcase
      rec_cnt_ff <= (state_ff == ST_REC && rec_cnt_ff < RECOV_CYC - 1) ? rec_cnt_ff + 32'h1
                  : (state_ff == ST_REC) ? rec_cnt_ff : 32'h0;
    end
  end

  // Grounded sinks are latched at start-up; LED faults are sticky per string.
  logic [1:0] grounded_ff;
  logic [1:0] led_fail_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      grounded_ff <= 2'b00;
      led_fail_ff <= 2'b00;
    end else if (clk_en) begin
      if (state_ff == ST_INIT) grounded_ff <= sink_grounded;  // R12
      led_fail_ff <= ((open_led | short_led) & ~grounded_ff & {2{state_ff == ST_ACT}})  // R21
                   | (led_fail_ff & {2{en_s}});
    end
  end

  // Sync input classification.
  ldc_sync_t   sm_ff;
  logic [8:0]  per_cnt_ff;
  logic [2:0]  good_ff;
  logic [31:0] hold_cnt_ff;
  logic        ss_static_ff;
  logic        in_range;
  logic        lost;
  assign in_range = per_cnt_ff >= 9'(SYNC_PMIN_CYC) && per_cnt_ff <= 9'(SYNC_PMAX_CYC);
  assign lost     = per_cnt_ff > 9'(SYNC_PMAX_CYC);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sm_ff        <= SM_STATIC;
      per_cnt_ff   <= '0;
      good_ff      <= '0;
      hold_cnt_ff  <= '0;
      ss_static_ff <= 1'b0;
    end else if (clk_en) begin
      if (sync_edge) per_cnt_ff <= 9'h001;
      else if (!lost) per_cnt_ff <= per_cnt_ff + 9'h001;
      if (sync_edge) good_ff <= in_range ? (good_ff == 3'(SYNC_LOCK_EDGES) ? good_ff
                                             : good_ff + 3'h1) : 3'h0;  // R23
      else if (lost) good_ff <= 3'h0;
      if (lost) ss_static_ff <= sync_s;  // R05
      unique case (sm_ff)
        SM_STATIC: if (good_ff == 3'(SYNC_LOCK_EDGES)) sm_ff <= SM_EXT;  // R01
        SM_EXT: if (lost || (sync_edge && !in_range)) begin
          sm_ff       <= sync_s ? SM_HOLD : SM_STATIC;  // R02 R03
          hold_cnt_ff <= 32'h0;
        end
        SM_HOLD: begin
          hold_cnt_ff <= hold_cnt_ff + 32'h1;
          if (!sync_s || sync_edge) sm_ff <= SM_STATIC;
          else if (hold_cnt_ff >= SS_DELAY_CYC - 1) sm_ff <= SM_STATIC;  // R04
        end
        default: sm_ff <= SM_STATIC;
      endcase
    end
  end

  // Triangle spread-spectrum offset in tenths of a percent.
  logic [31:0]       ss_cnt_ff;
  logic signed [6:0] ss_off_ff;
  logic              ss_up_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ss_cnt_ff <= '0;
      ss_off_ff <= '0;
      ss_up_ff  <= 1'b1;
    end else if (clk_en) begin
      if (ss_cnt_ff >= SS_STEP_CYC - 1) begin
        ss_cnt_ff <= 32'h0;
        if (ss_up_ff && ss_off_ff >= 7'(SS_DEV_TENTHS - 1)) ss_up_ff <= 1'b0;
        if (!ss_up_ff && ss_off_ff <= 7'(1 - SS_DEV_TENTHS)) ss_up_ff <= 1'b1;
        ss_off_ff <= ss_up_ff ? ss_off_ff + 7'sh01 : ss_off_ff - 7'sh01;  // R06
      end else begin
        ss_cnt_ff <= ss_cnt_ff + 32'h1;
      end
    end
  end

  // Switch current limit boost and cool-down.
  logic [31:0] ilim_cnt_ff;
  logic        ilim_high_ff;
  logic        ilim_cool_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ilim_cnt_ff  <= '0;
      ilim_high_ff <= 1'b0;
      ilim_cool_ff <= 1'b0;
    end else if (clk_en) begin
      if (ilim_high_ff || ilim_cool_ff) begin
        if (ilim_cnt_ff >= ILIM_CYC - 1) begin
          ilim_cnt_ff  <= 32'h0;
          ilim_cool_ff <= ilim_high_ff;  // R11
          ilim_high_ff <= 1'b0;  // R10
        end else begin
          ilim_cnt_ff <= ilim_cnt_ff + 32'h1;
        end
      end else if (ilim_reached && state_ff == ST_ACT) begin
        ilim_high_ff <= 1'b1;  // R10
      end
    end
  end

  // Registered outputs.
  ldc_dcdc_t  nxt_dcdc;
  logic [7:0] gate_ff;
  logic [31:0] gate_cnt_ff;
  logic       on;
  assign on = state_ff == ST_ACT;
  always_comb begin
    nxt_dcdc           = '0;
    nxt_dcdc.conv_en   = on;  // R02 R16
    nxt_dcdc.ext_sync  = sm_ff == SM_EXT;
    nxt_dcdc.spread_en = sm_ff == SM_STATIC && ss_static_ff;  // R05 R07
    nxt_dcdc.ss_offset = nxt_dcdc.spread_en ? ss_off_ff : 7'sh00;  // R06
    nxt_dcdc.ilim_high = ilim_high_ff;
    nxt_dcdc.start_pct = 7'(START_PCT);  // R16
    nxt_dcdc.blank_ns  = BLANK_NS;
    if (fsw_khz < RNG1_TOP_KHZ) begin
      nxt_dcdc.range      = 2'h0;
      nxt_dcdc.min_off_ns = TOFF_R1_NS;  // R09
    end else if (fsw_khz < RNG2_TOP_KHZ) begin
      nxt_dcdc.range      = 2'h1;
      nxt_dcdc.min_off_ns = TOFF_R2_NS;
    end else if (fsw_khz < RNG3_TOP_KHZ) begin
      nxt_dcdc.range      = 2'h2;
      nxt_dcdc.min_off_ns = TOFF_R34_NS;
    end else begin
      nxt_dcdc.range      = 2'h3;
      nxt_dcdc.min_off_ns = TOFF_R34_NS;
      nxt_dcdc.blank_ns   = BLANK_R4_NS;  // R09
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dcdc          <= '0;
      led_sink_one  <= 1'b0;
      led_sink_two  <= 1'b0;
      sink_disabled <= 2'b00;
      fault_pin_oe  <= 1'b0;
    end else if (clk_en) begin
      dcdc          <= nxt_dcdc;
      led_sink_one  <= pwm_s & on & en_s & ~grounded_ff[0] & ~led_fail_ff[0];  // R13 R15
      led_sink_two  <= pwm_s & on & en_s & ~grounded_ff[1] & ~led_fail_ff[1];  // R13 R15
      sink_disabled <= grounded_ff | led_fail_ff;  // R12
      fault_pin_oe  <= state_ff == ST_REC || (|led_fail_ff);  // R21 R22
    end
  end
  assign fault_pin_out = 1'b0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate_ff     <= '0;
      gate_cnt_ff <= '0;
    end else if (clk_en) begin
      if (state_ff == ST_STBY || state_ff == ST_REC || !vin_above_vgs) begin
        gate_ff     <= 8'h00;  // R18 R19
        gate_cnt_ff <= 32'h0;
      end else if (gate_cnt_ff >= GATE_STEP_CYC - 1) begin
        gate_cnt_ff <= 32'h0;
        if (gate_ff < 8'(GATE_MAX_UA)) gate_ff <= gate_ff + 8'h01;  // R17
      end else begin
        gate_cnt_ff <= gate_cnt_ff + 32'h1;
      end
    end
  end
  assign power_fet_gate_control = gate_ff;

  sequence s_lost_high;
    sm_ff == SM_EXT && lost && sync_s;
  endsequence
  sequence s_hold_quiet;
    sm_ff == SM_HOLD [*8];
  endsequence
  property p_lock;
    @(posedge clk) disable iff (sys_rst)
      clk_en && $rose(sm_ff == SM_EXT) |-> $past(good_ff) == 3'(SYNC_LOCK_EDGES);
  endproperty
  a_lock: assert property (p_lock) else $error("Sync locked too early.");  // R01 R23
  property p_ext_no_ss;
    @(posedge clk) disable iff (sys_rst) clk_en && dcdc.ext_sync |-> !dcdc.spread_en;
  endproperty
  a_ext_no_ss: assert property (p_ext_no_ss) else $error("Spread on in sync mode.");  // R07
  property p_lost_low;
    @(posedge clk) disable iff (sys_rst)
      clk_en && sm_ff == SM_EXT && lost && !sync_s |=> sm_ff == SM_STATIC;
  endproperty
  a_lost_low: assert property (p_lost_low) else $error("Lost low sync not static.");  // R03
  property p_lost_high;
    @(posedge clk) disable iff (sys_rst)
      clk_en ##0 s_lost_high |=> s_hold_quiet ##0 !dcdc.spread_en;
  endproperty
  a_lost_high: assert property (p_lost_high) else $error("Spread resumed early.");  // R04
  property p_range;
    @(posedge clk) disable iff (sys_rst)
      clk_en && fsw_khz < RNG1_TOP_KHZ |=> !clk_en || dcdc.min_off_ns == TOFF_R1_NS;
  endproperty
  a_range: assert property (p_range) else $error("Range 1 off time wrong.");  // R09
  property p_ilim;
    @(posedge clk) disable iff (sys_rst) ilim_high_ff |-> ilim_cnt_ff < ILIM_CYC && !ilim_cool_ff;
  endproperty
  a_ilim: assert property (p_ilim) else $error("Boost window broken.");  // R10 R11
  property p_pwm;
    @(posedge clk) disable iff (sys_rst) clk_en && on && en_s && !grounded_ff[0] && !led_fail_ff[0]
      |=> !clk_en || led_sink_one == $past(pwm_s);
  endproperty
  a_pwm: assert property (p_pwm) else $error("Sink one not following PWM.");  // R13
  property p_rec;
    @(posedge clk) disable iff (sys_rst) clk_en && state_ff == ST_REC ##1 clk_en
      |-> fault_pin_oe && power_fet_gate_control == 8'h00 && !dcdc.conv_en;
  endproperty
  a_rec: assert property (p_rec) else $error("Recovery outputs wrong.");  // R19 R22
  property p_gate;
    @(posedge clk) disable iff (sys_rst) power_fet_gate_control != $past(power_fet_gate_control)
      |-> power_fet_gate_control == 8'h00
          || power_fet_gate_control == $past(power_fet_gate_control) + 8'h01;
  endproperty
  a_gate: assert property (p_gate) else $error("Gate ramp not gradual.");  // R17 R18
endmodule : ldc_ctrl

// [hw/ldc_pkg.sv]
// Constants and carrier types for the LED driver converter control block.
// Assumes a 100 MHz system clock.
package ldc_pkg;
  localparam int CLK_MHZ       = 100;
  localparam int SYNC_FMIN_KHZ = 300;
  localparam int SYNC_FMAX_KHZ = 2200;
  localparam int SYNC_PMIN_CYC = (CLK_MHZ * 1000) / SYNC_FMAX_KHZ;
  localparam int SYNC_PMAX_CYC = (CLK_MHZ * 1000 + SYNC_FMIN_KHZ - 1) / SYNC_FMIN_KHZ;
  localparam int SYNC_LOCK_EDGES = 4;
  localparam int SS_DELAY_US   = 256;
  localparam int SS_PERIOD_US  = 1000;
  localparam int SS_DEV_TENTHS = 30;
  localparam int SS_STEP_CYC   = (SS_PERIOD_US * CLK_MHZ) / (4 * SS_DEV_TENTHS);
  localparam int ILIM_MS       = 1500;
  localparam int RECOV_MS      = 100;
  localparam int EN_SHORT_US   = 20;
  localparam int EN_SHORT_CYC  = EN_SHORT_US * CLK_MHZ;
  localparam int GATE_MAX_UA   = 230;
  localparam int START_PCT     = 88;
  localparam logic [11:0] RNG1_TOP_KHZ = 12'h1e0;
  localparam logic [11:0] RNG2_TOP_KHZ = 12'h47e;
  localparam logic [11:0] RNG3_TOP_KHZ = 12'h672;
  localparam logic [7:0] TOFF_R1_NS  = 8'h96;
  localparam logic [7:0] TOFF_R2_NS  = 8'h3c;
  localparam logic [7:0] TOFF_R34_NS = 8'h28;
  localparam logic [6:0] BLANK_NS    = 7'h5f;
  localparam logic [6:0] BLANK_R4_NS = 7'h46;

  typedef enum logic [1:0] {
    ST_STBY = 2'b00,
    ST_INIT = 2'b01,
    ST_ACT  = 2'b11,
    ST_REC  = 2'b10
  } ldc_state_t;

  typedef enum logic [1:0] {
    SM_STATIC = 2'b00,
    SM_EXT    = 2'b01,
    SM_HOLD   = 2'b11
  } ldc_sync_t;

  typedef struct packed {
    logic ovp;
    logic uvlo;
    logic ocp;
    logic over_temperature_fault;
  } ldc_faults_t;

  typedef struct packed {
    logic              conv_en;
    logic              ext_sync;
    logic              spread_en;
    logic signed [6:0] ss_offset;
    logic [1:0]        range;
    logic [7:0]        min_off_ns;
    logic [6:0]        blank_ns;
    logic              ilim_high;
    logic [6:0]        start_pct;
  } ldc_dcdc_t;
endpackage : ldc_pkg

// [test/ldc_host_model.sv]
// Host model: drives the enable, brightness and sync pins of the control block.
// Assumes the bench gives requests at rising clock edges.
module ldc_host_model (
  // Clock.
  input  wire logic       clk,
  // Requests from the bench.
  input  wire logic       en_req,
  input  wire logic       pwm_req,
  input  wire logic [1:0] sync_mode,
  input  wire logic [8:0] sync_half,
  // Pins towards the block.
  output logic            io_supply_enable_input,
  output logic            pwm_in,
  output logic            sync_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [8:0] half_cnt_ff;

  initial begin
    io_supply_enable_input = 1'b0;
    pwm_in                 = 1'b0;
    sync_in                = 1'b0;
    half_cnt_ff            = 9'h000;
  end

  always @(posedge clk) begin
    io_supply_enable_input <= en_req;
    pwm_in                 <= pwm_req;
  end

  // Mode 2 toggles the sync pin every sync_half cycles, others hold a level.
  always @(posedge clk) begin
    if (sync_mode == 2'h2) begin
      half_cnt_ff <= (half_cnt_ff + 9'h001 >= sync_half) ? 9'h000 : half_cnt_ff + 9'h001;
      if (half_cnt_ff + 9'h001 >= sync_half) begin
        sync_in <= ~sync_in;
      end
    end else begin
      half_cnt_ff <= 9'h000;
      sync_in     <= sync_mode[0];
    end
  end
endmodule : ldc_host_model

// [test/tb.sv]
// Self-checking bench of the LED driver control block.
// Assumes short test values for the long timing parameters.
module tb;
  import ldc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        en_req = 1'b0;
  logic        pwm_req = 1'b0;
  logic [1:0]  sync_mode = 2'h0;
  logic        en_pin;
  logic        pwm_pin;
  logic        sync_pin;
  ldc_faults_t fault_in = '0;
  logic        vin_above_vgs = 1'b0;
  logic        ilim_reached = 1'b0;
  logic [1:0]  sink_grounded = 2'h2;
  logic [1:0]  open_led = 2'h0;
  logic [1:0]  short_led = 2'h0;
  logic [11:0] fsw_khz = 12'h190;
  ldc_dcdc_t   dcdc;
  logic        sink1;
  logic        sink2;
  logic [1:0]  sink_disabled;
  logic [7:0]  gate;
  logic        fault_out;
  logic        fault_oe;
  int          err_count = 0;
  int          compares = 0;
  int          seed = 32'h6523;
  int          on_t;
  int          highs;

  always #5 clk = ~clk;

  ldc_host_model i_host (.clk(clk), .en_req(en_req), .pwm_req(pwm_req), .sync_mode(sync_mode),
    .sync_half(9'h064), .io_supply_enable_input(en_pin), .pwm_in(pwm_pin), .sync_in(sync_pin));

  ldc_ctrl #(.SS_DELAY_CYC(40), .ILIM_CYC(20), .RECOV_CYC(30), .GATE_STEP_CYC(1)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .io_supply_enable_input(en_pin),
    .pwm_in(pwm_pin), .sync_in(sync_pin), .fault_in(fault_in), .vin_above_vgs(vin_above_vgs),
    .ilim_reached(ilim_reached), .sink_grounded(sink_grounded), .open_led(open_led),
    .short_led(short_led), .fsw_khz(fsw_khz), .dcdc(dcdc), .led_sink_one(sink1),
    .led_sink_two(sink2), .sink_disabled(sink_disabled), .power_fet_gate_control(gate),
    .fault_pin_out(fault_out), .fault_pin_oe(fault_oe));

  function automatic logic [16:0] exp_par(input logic [11:0] f);
    if (f < RNG1_TOP_KHZ) return {2'h0, TOFF_R1_NS, BLANK_NS};
    if (f < RNG2_TOP_KHZ) return {2'h1, TOFF_R2_NS, BLANK_NS};
    if (f < RNG3_TOP_KHZ) return {2'h2, TOFF_R34_NS, BLANK_NS};
    return {2'h3, TOFF_R34_NS, BLANK_R4_NS};
  endfunction : exp_par

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk_bit(input string what, input logic exp, input logic got);
    #1;
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_val(input string what, input logic [16:0] exp, input logic [16:0] got);
    #1;
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic stop_test;
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  initial begin
    cyc(40000);
    err_count++;
    stop_test();
  end

  initial begin
    cyc(2);
    chk_val("outputs in reset", 17'h0, {dcdc.conv_en, gate, fault_oe, sink1, fault_out});
    cyc(2);
    sys_rst <= 1'b0;
    en_req  <= 1'b1;
    cyc(50);
    chk_bit("converter on", 1'b1, dcdc.conv_en);
    chk_val("start level", 17'd88, 17'(dcdc.start_pct));
    chk_val("gate without vin", 17'h0, 17'(gate));
    chk_val("sink disabled", 17'h2, 17'(sink_disabled));
    vin_above_vgs <= 1'b1;
    cyc(20);
    chk_bit("gate ramping", 1'b1, gate > 8'h00 && gate < 8'he6);
    cyc(300);
    chk_val("gate full", 17'd230, 17'(gate));
    $display("test start done");
    for (int i = 0; i < 4; i++) begin
      fsw_khz <= (i == 0) ? 12'h190 : (i == 1) ? 12'h320 : (i == 2) ? 12'h578 : 12'h7d0;
      cyc(10);
      chk_val("parameter set", exp_par(fsw_khz), {dcdc.range, dcdc.min_off_ns, dcdc.blank_ns});
    end
    fsw_khz <= 12'h190;
    $display("test range done");
    for (int p = 0; p < 4; p++) begin
      on_t = (p == 0) ? 50 : 50 + int'($unsigned($random(seed)) % 4900);
      pwm_req <= 1'b1;
      cyc(1);
      chk_bit("sink one early", 1'b0, sink1);
      cyc(5);
      chk_bit("sink one on", 1'b1, sink1);
      chk_bit("grounded sink off", 1'b0, sink2);
      cyc(on_t - 6);
      pwm_req <= 1'b0;
      cyc(6);
      chk_bit("sink one off", 1'b0, sink1);
      cyc(5000 - on_t - 6);
    end
    $display("test pwm done");
    sync_mode <= 2'h1;
    cyc(500);
    chk_val("static high", 17'h1, {dcdc.ext_sync, dcdc.spread_en});
    cyc(900);
    chk_bit("offset moving", 1'b1, dcdc.ss_offset != 7'sd0);
    chk_bit("offset bounded", 1'b1, dcdc.ss_offset >= -7'sd30 && dcdc.ss_offset <= 7'sd30);
    sync_mode <= 2'h2;
    cyc(1500);
    chk_val("locked", 17'h2, {dcdc.ext_sync, dcdc.spread_en});
    chk_val("offset locked", 17'h0, 17'(dcdc.ss_offset));
    sync_mode <= 2'h1;
    cyc(20);
    chk_bit("spread held off", 1'b0, dcdc.spread_en);
    cyc(500);
    chk_val("lost high", 17'h1, {dcdc.ext_sync, dcdc.spread_en});
    sync_mode <= 2'h2;
    cyc(1500);
    chk_bit("relocked", 1'b1, dcdc.ext_sync);
    sync_mode <= 2'h0;
    cyc(500);
    chk_val("lost low", 17'h0, {dcdc.ext_sync, dcdc.spread_en});
    $display("test sync done");
    ilim_reached <= 1'b1;
    cyc(1);
    ilim_reached <= 1'b0;
    cyc(5);
    chk_bit("boost on", 1'b1, dcdc.ilim_high);
    cyc(20);
    chk_bit("boost over", 1'b0, dcdc.ilim_high);
    ilim_reached <= 1'b1;
    cyc(5);
    chk_bit("cooldown", 1'b0, dcdc.ilim_high);
    cyc(60);
    highs = 0;
    repeat (84) begin
      cyc(1);
      #1;
      highs += int'(dcdc.ilim_high);
    end
    chk_bit("overload cycle", 1'b1, highs >= 38 && highs <= 44);
    ilim_reached <= 1'b0;
    $display("test limit done");
    pwm_req  <= 1'b1;
    open_led <= 2'h1;
    cyc(10);
    chk_val("led fault", 17'h7, {fault_oe, dcdc.conv_en, sink_disabled[0]});
    open_led <= 2'h0;
    en_req   <= 1'b0;
    cyc(100);
    en_req <= 1'b1;
    cyc(10);
    chk_val("led fault cleared", 17'h1, {fault_oe, dcdc.conv_en});
    short_led <= 2'h2;
    cyc(10);
    chk_val("grounded sink fault", 17'h2, {fault_oe, sink_disabled});
    short_led <= 2'h0;
    fault_in <= 4'h8;
    cyc(10);
    chk_val("recovery", 17'h400, {fault_oe, gate, dcdc.conv_en, sink1});
    cyc(60);
    chk_bit("fault kept", 1'b1, fault_oe);
    fault_in <= 4'h0;
    cyc(50);
    chk_val("recovered", 17'h1, {fault_oe, dcdc.conv_en});
    clk_en <= 1'b0;
    en_req <= 1'b0;
    cyc(50);
    chk_val("frozen", 17'h3, {dcdc.conv_en, sink1});
    clk_en <= 1'b1;
    cyc(2120);
    chk_val("shutdown", 17'h0, {dcdc.conv_en, gate, sink1});
    $display("test fault done");
    stop_test();
  end
endmodule : tb
